// >>> mct_ce_model.sv
// ----------------------------------------------------------------------
// Control electronics on four trunks
// ----------------------------------------------------------------------
module mct_ce_model (
  input  wire logic        core_clk_i,
  input  wire logic [3:0]  pwr_on_i,
  input  wire logic [3:0]  end_req_i,
  input  wire logic [3:0]  rdy_req_i,
  input  wire logic [3:0]  strobe_i,
  input  wire logic [8:0]  dout_i,
  output logic      [3:0]  power_o,
  output logic      [3:0]  end_o,
  output logic      [3:0]  ready_o,
  output logic      [35:0] din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] held [4];
  logic       tog;

  // Power-up byte of each trunk
  initial begin
    tog = 1'b0;
    for (int t = 0; t < 4; t++)
      held[t] = 9'h050 + 9'(t);
  end

  // Only a strobed trunk takes the output byte
  always @(posedge core_clk_i) begin
    tog <= ~tog;
    for (int t = 0; t < 4; t++)
      if (strobe_i[t]) held[t] <= dout_i;
  end

  // Lines are valid only with power, otherwise they chatter
  always_comb begin
    power_o = pwr_on_i;
    for (int t = 0; t < 4; t++) begin
      end_o[t]        = pwr_on_i[t] ? end_req_i[t] : tog;
      ready_o[t]      = pwr_on_i[t] ? rdy_req_i[t] : ~tog;
      din_o[t*9 +: 9] = pwr_on_i[t] ? held[t] : {9{tog}};
    end
  end
endmodule

// >>> mct_consts.vh
`ifndef MCT_CONSTS_VH
`define MCT_CONSTS_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define MCT_NTRUNK        4
`define MCT_BYTE_W        9
`define MCT_BUS_W         32

// ----------------------------------------------------------------------
// Output byte bit positions
// ----------------------------------------------------------------------
`define MCT_BIT_SSTAT_LO  1
`define MCT_BIT_SSTAT_HI  2
`define MCT_BIT_NOOP      3
`define MCT_BIT_SETINT    5
`define MCT_BIT_SWEND     6
`define MCT_BIT_WRU       7
`define MCT_BIT_PARITY    8

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define MCT_OP_HALT_IO    8'h9E
`define MCT_OP_TEST_DEV   8'h9D

// ----------------------------------------------------------------------
// Register offsets (byte addresses) and field positions
// ----------------------------------------------------------------------
`define MCT_ADDR_W        4
`define MCT_OFF_CTRL      4'h0
`define MCT_OFF_DOUT      4'h4
`define MCT_OFF_STAT      4'h8
`define MCT_OFF_DIN       4'hC
// CTRL fields
`define MCT_CTL_SET_READ  0
`define MCT_CTL_SET_NOOP  1
`define MCT_CTL_SET_SINT  2
`define MCT_CTL_SET_SWE   3
`define MCT_CTL_SET_SST   4
`define MCT_CTL_SET_WRU   5
`define MCT_CTL_CLR_RDY   6
`define MCT_CTL_CLR_DOUT  7
`define MCT_CTL_PHASE_LO  8
`define MCT_CTL_PHASE_W   2
`define MCT_CTL_STROBE    10
`define MCT_CTL_ACTIVATE  11
`define MCT_CTL_BYTE_TYPE 12
// Phase encodings for direct sets
`define MCT_PH_IDLE       2'h0
`define MCT_PH_INIT       2'h1
`define MCT_PH_TERM       2'h2
`define MCT_PH_INTR       2'h3

// ----------------------------------------------------------------------
// Status level codes and reset values
// ----------------------------------------------------------------------
`define MCT_STL_W         3
`define MCT_STL_IDLE      3'h0
`define MCT_STL_4B2       3'h1
`define MCT_STL_5BM1      3'h2
`define MCT_STL_SEND      3'h3
`define MCT_STL_HALT      3'h4
`define MCT_STL_TEST      3'h5
`define MCT_STL_INTR      3'h6
`define MCT_STL_END       3'h7
`define MCT_DOUT_RST      9'h000

`endif

// >>> mct_if_chk_properties.sv
`include "mct_consts.vh"

// ----------------------------------------------------------------------
// Port checker of the trunk interface
// ----------------------------------------------------------------------
module mct_if_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [3:0]  trunk_device_power_i,
  input wire logic [3:0]  trunk_service_select_i,
  input wire logic [3:0]  trunk_end_i,
  input wire logic [3:0]  trunk_strobe_o,
  input wire logic [3:0]  trunk_activate_o,
  input wire logic        input_permit_release_i,
  input wire logic        selector_channel_end_i,
  input wire logic        selector_inhibit_i,
  input wire logic [8:0]  byte_path_bits_o,
  input wire logic        aggregate_end_o,
  input wire logic        aggregate_end_n_o,
  input wire logic        combined_end_o,
  input wire logic        channel_end_request_o,
  input wire logic        byte_type_qualifier_o,
  input wire logic        end_lamp_o,
  input wire logic [2:0]  status_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Arming write of the read permit, and its release in read data move
  sequence s_arm;
    avs_write_i && avs_address_i == `MCT_OFF_CTRL && avs_byteenable_i[0] &&
      avs_writedata_i[`MCT_CTL_SET_READ] && status_level_o == `MCT_STL_IDLE;
  endsequence
  sequence s_drop;
    status_level_o == `MCT_STL_5BM1 && input_permit_release_i;
  endsequence

  // End qualification, polarity and fan-out
  AST_END_QUAL: assert property (
    aggregate_end_o == |(trunk_end_i & trunk_device_power_i & trunk_service_select_i))
    else $error("aggregate end mismatch");
  AST_END_POL: assert property (aggregate_end_n_o == !aggregate_end_o)
    else $error("aggregate end polarity mismatch");
  AST_COMB_END: assert property (
    combined_end_o == (aggregate_end_o | selector_channel_end_i))
    else $error("combined end mismatch");
  AST_END_LAMP: assert property (end_lamp_o == aggregate_end_o)
    else $error("end lamp mismatch");
  AST_END_REQ: assert property (channel_end_request_o == combined_end_o)
    else $error("end request mismatch");

  // Byte type qualifier follows the control write
  AST_BYTE_TYPE: assert property (
    (avs_write_i && avs_address_i == `MCT_OFF_CTRL && avs_byteenable_i[1]) |=>
      byte_type_qualifier_o == $past(avs_writedata_i[`MCT_CTL_BYTE_TYPE]))
    else $error("byte type qualifier not loaded");

  // Byte path closing and trunk gating
  AST_PATH_INH: assert property (
    (status_level_o == `MCT_STL_5BM1 || selector_inhibit_i) |-> byte_path_bits_o == 9'h000)
    else $error("byte path open while inhibited");
  AST_STROBE_SEL: assert property (
    ((trunk_strobe_o | trunk_activate_o) & ~trunk_service_select_i) == 4'h0)
    else $error("strobe or activate on unselected trunk");

  // Read permit arming and withdrawal
  AST_PERMIT_ARM: assert property (s_arm |=> status_level_o == `MCT_STL_5BM1)
    else $error("read arm did not enter read data move");
  AST_PERMIT_DROP: assert property (s_drop |=> status_level_o == `MCT_STL_IDLE)
    else $error("release did not end read data move");
endmodule

bind mct_trunk_if mct_if_chk mct_if_chk_inst (
  .core_clk_i, .rst_n_i, .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .channel_end_request_o, .byte_type_qualifier_o,
  .trunk_device_power_i, .trunk_service_select_i, .trunk_end_i, .trunk_strobe_o,
  .trunk_activate_o, .input_permit_release_i, .selector_channel_end_i, .selector_inhibit_i,
  .byte_path_bits_o, .aggregate_end_o, .aggregate_end_n_o, .combined_end_o, .end_lamp_o,
  .status_level_o
);

// >>> mct_trunk_if.v
`include "mct_consts.vh"

module mct_trunk_if (
  input  wire                                core_clk_i,
  input  wire                                rst_n_i,
  // Avalon-MM slave
  input  wire [`MCT_ADDR_W-1:0]              avs_address_i,
  input  wire                                avs_read_i,
  input  wire                                avs_write_i,
  input  wire [31:0]                         avs_writedata_i,
  input  wire [3:0]                          avs_byteenable_i,
  output reg  [31:0]                         avs_readdata_o,
  output wire                                avs_waitrequest_o,
  output wire [1:0]                          avs_response_o,
  // Trunk receivers
  input  wire [`MCT_NTRUNK-1:0]              trunk_device_power_i,
  input  wire [`MCT_NTRUNK-1:0]              trunk_service_select_i,
  input  wire [`MCT_NTRUNK-1:0]              trunk_end_i,
  input  wire [`MCT_NTRUNK-1:0]              trunk_ready_i,
  input  wire [`MCT_NTRUNK*`MCT_BYTE_W-1:0]  trunk_din_i,
  // Trunk transmitters
  output wire [`MCT_BYTE_W-1:0]              channel_output_reg_o,
  output wire [`MCT_NTRUNK-1:0]              trunk_strobe_o,
  output wire [`MCT_NTRUNK-1:0]              trunk_activate_o,
  output wire                                byte_type_qualifier_o,
  // Processor side
  input  wire                                input_permit_release_i,
  input  wire                                selector_channel_end_i,
  input  wire                                selector_inhibit_i,
  input  wire [`MCT_BUS_W-1:0]               processor_bus_n_i,
  input  wire [7:0]                          instruction_code_i,
  input  wire [1:0]                          condition_code_i,
  input  wire                                interrupt_cond_i,
  input  wire                                n_count_zero_i,
  input  wire [1:0]                          channel_char_address_i,
  input  wire                                read_input_command_i,
  input  wire                                read_register_command_i,
  output wire [`MCT_BUS_W-1:0]               internal_bus_inverted_o,
  output wire [`MCT_BYTE_W-1:0]              byte_path_bits_o,
  output reg  [7:0]                          processor_data_o,
  output wire                                aggregate_end_o,
  output wire                                aggregate_end_n_o,
  output wire                                combined_end_o,
  output wire                                channel_end_request_o,
  output wire                                end_lamp_o,
  output wire [`MCT_STL_W-1:0]               status_level_o
);

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;

  // Release reset through two flops
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ----------------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------------
  reg [`MCT_BYTE_W-1:0]  dout_reg;
  reg [`MCT_BYTE_W-1:0]  dout_next;
  reg                    ready_flag_reg;
  reg                    permit_arm_reg;
  reg [`MCT_STL_W-1:0]   stl_reg;
  reg [`MCT_STL_W-1:0]   stl_next;
  reg [`MCT_CTL_PHASE_W-1:0] phase_reg;
  reg                    strobe_reg;
  reg                    activate_reg;
  reg                    byte_type_reg;

  // ----------------------------------------------------------------------
  // End and ready qualification
  // ----------------------------------------------------------------------
  wire [`MCT_NTRUNK-1:0] trunk_end_qualified;
  wire [`MCT_NTRUNK-1:0] trunk_ready_qualified;
  wire [`MCT_NTRUNK-1:0] trunk_input_permit;
  wire [`MCT_BYTE_W-1:0] din_gated [0:`MCT_NTRUNK-1];
  wire [`MCT_BYTE_W-1:0] din_or    [0:`MCT_NTRUNK];

  assign din_or[0] = {`MCT_BYTE_W{1'b0}};

  // Per-trunk qualification, permit gating and input OR chain
  genvar t;
  generate
    for (t = 0; t < `MCT_NTRUNK; t = t + 1) begin : g_trunk
      assign trunk_end_qualified[t] = trunk_end_i[t] & trunk_device_power_i[t]
                                      & trunk_service_select_i[t];
      assign trunk_ready_qualified[t] = trunk_ready_i[t] & trunk_device_power_i[t]
                                        & trunk_service_select_i[t];
      assign trunk_input_permit[t] = permit_arm_reg & trunk_service_select_i[t];
      assign din_gated[t] = trunk_din_i[t*`MCT_BYTE_W +: `MCT_BYTE_W]
                            & {`MCT_BYTE_W{trunk_input_permit[t]}};
      assign din_or[t+1] = din_or[t] | din_gated[t];
      assign trunk_strobe_o[t]   = strobe_reg & trunk_service_select_i[t];
      assign trunk_activate_o[t] = activate_reg & trunk_service_select_i[t];
    end
  endgenerate

  wire [`MCT_BYTE_W-1:0] channel_input_bus = din_or[`MCT_NTRUNK];

  // Aggregate end in both polarities
  assign aggregate_end_o       = |trunk_end_qualified;
  assign aggregate_end_n_o     = ~aggregate_end_o;
  assign combined_end_o        = aggregate_end_o | selector_channel_end_i;
  assign channel_end_request_o = combined_end_o;
  assign end_lamp_o            = aggregate_end_o;

  // ----------------------------------------------------------------------
  // Processor bus and byte path
  // ----------------------------------------------------------------------
  // Inverters forming the internal bus
  assign internal_bus_inverted_o = ~processor_bus_n_i;

  wire byte_path_open = (stl_reg != `MCT_STL_5BM1) & ~selector_inhibit_i;
  assign byte_path_bits_o = channel_input_bus & {`MCT_BYTE_W{byte_path_open}};

  // Character select decode, lane 0 carries the byte
  wire character_select = (channel_char_address_i == 2'h0);

  // Data placed on the processor bus
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      processor_data_o <= 8'h00;
    end else if (read_input_command_i & character_select) begin
      processor_data_o <= channel_input_bus[7:0];
    end else if (read_register_command_i & character_select) begin
      processor_data_o <= dout_reg[7:0];
    end else begin
      processor_data_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM decode
  // ----------------------------------------------------------------------
  wire wr_ctrl = avs_write_i & (avs_address_i == `MCT_OFF_CTRL);
  wire wr_dout = avs_write_i & (avs_address_i == `MCT_OFF_DOUT);
  wire [31:0] wdata = avs_writedata_i;
  wire [1:0]  wr_phase = wdata[`MCT_CTL_PHASE_LO +: `MCT_CTL_PHASE_W];

  // Answer every access in the cycle it is presented
  assign avs_waitrequest_o = 1'b0;
  assign avs_response_o    = 2'h0;

  // Read mux; unmapped reads return zero
  always @* begin
    if (avs_address_i == `MCT_OFF_CTRL) begin
      avs_readdata_o = {19'h00000, byte_type_reg, activate_reg, strobe_reg,
                        phase_reg, 8'h00};
    end else if (avs_address_i == `MCT_OFF_DOUT) begin
      avs_readdata_o = {23'h000000, dout_reg};
    end else if (avs_address_i == `MCT_OFF_STAT) begin
      avs_readdata_o = {24'h000000, aggregate_end_o, combined_end_o,
                        permit_arm_reg, ready_flag_reg, 1'b0, stl_reg};
    end else if (avs_address_i == `MCT_OFF_DIN) begin
      avs_readdata_o = {23'h000000, channel_input_bus};
    end else begin
      avs_readdata_o = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Output register with direct bit sets
  // ----------------------------------------------------------------------
  always @* begin
    dout_next = dout_reg;
    if (wr_dout & avs_byteenable_i[0]) begin
      dout_next[7:0] = internal_bus_inverted_o[7:0];
    end
    if (wr_dout & avs_byteenable_i[1]) begin
      dout_next[`MCT_BIT_PARITY] = internal_bus_inverted_o[`MCT_BIT_PARITY];
    end
    if (wr_ctrl & avs_byteenable_i[0]) begin
      if (wdata[`MCT_CTL_CLR_DOUT]) begin
        dout_next = `MCT_DOUT_RST;
      end
      if (wdata[`MCT_CTL_SET_NOOP] &
          ((wr_phase == `MCT_PH_INIT) | (wr_phase == `MCT_PH_INTR))) begin
        dout_next[`MCT_BIT_NOOP] = 1'b1;
      end
      if (wdata[`MCT_CTL_SET_SINT] & (wr_phase == `MCT_PH_TERM)) begin
        dout_next[`MCT_BIT_SETINT] = 1'b1;
      end else if (wdata[`MCT_CTL_SET_SWE] & (wr_phase == `MCT_PH_TERM)) begin
        dout_next[`MCT_BIT_SWEND] = 1'b1;
      end
      if (wdata[`MCT_CTL_SET_SST]) begin
        dout_next[`MCT_BIT_SSTAT_LO] = 1'b1;
        dout_next[`MCT_BIT_SSTAT_HI] = 1'b1;
      end
      if (wdata[`MCT_CTL_SET_WRU]) begin
        dout_next[`MCT_BIT_WRU] = 1'b1;
      end
    end
  end

  assign channel_output_reg_o  = dout_reg;
  assign byte_type_qualifier_o = byte_type_reg;

  // ----------------------------------------------------------------------
  // Status level sequencer
  // ----------------------------------------------------------------------
  always @* begin
    stl_next = stl_reg;
    case (stl_reg)
      `MCT_STL_IDLE: begin
        if (wr_ctrl & avs_byteenable_i[0] & wdata[`MCT_CTL_SET_READ]) begin
          stl_next = `MCT_STL_5BM1;
        end else if (instruction_code_i == `MCT_OP_HALT_IO) begin
          stl_next = `MCT_STL_HALT;
        end else if (instruction_code_i == `MCT_OP_TEST_DEV) begin
          stl_next = `MCT_STL_TEST;
        end
      end
      `MCT_STL_HALT: begin
        stl_next = `MCT_STL_4B2;
      end
      `MCT_STL_TEST: begin
        stl_next = `MCT_STL_4B2;
      end
      `MCT_STL_4B2: begin
        // Stay while waiting for ready
        if (!ready_flag_reg) begin
          stl_next = `MCT_STL_4B2;
        end else if (interrupt_cond_i) begin
          stl_next = `MCT_STL_INTR;
        end else if (condition_code_i != 2'h0) begin
          stl_next = `MCT_STL_END;
        end else if ((instruction_code_i == `MCT_OP_HALT_IO) | !n_count_zero_i) begin
          stl_next = `MCT_STL_SEND;
        end else begin
          stl_next = `MCT_STL_END;
        end
      end
      `MCT_STL_5BM1: begin
        if (input_permit_release_i) begin
          stl_next = `MCT_STL_IDLE;
        end
      end
      `MCT_STL_SEND: begin
        stl_next = `MCT_STL_END;
      end
      `MCT_STL_INTR: begin
        stl_next = `MCT_STL_END;
      end
      default: begin
        stl_next = `MCT_STL_IDLE;
      end
    endcase
  end

  assign status_level_o = stl_reg;

  // ----------------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg       <= `MCT_DOUT_RST;
      ready_flag_reg <= 1'b0;
      permit_arm_reg <= 1'b0;
      stl_reg        <= `MCT_STL_IDLE;
      phase_reg      <= `MCT_PH_IDLE;
      strobe_reg     <= 1'b0;
      activate_reg   <= 1'b0;
      byte_type_reg  <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      stl_reg  <= stl_next;
      // Ready set wins over software clear
      if (|trunk_ready_qualified) begin
        ready_flag_reg <= 1'b1;
      end else if (wr_ctrl & avs_byteenable_i[0] & wdata[`MCT_CTL_CLR_RDY]) begin
        ready_flag_reg <= 1'b0;
      end
      // Permit armed on receive, withdrawn at D5 time
      if (input_permit_release_i) begin
        permit_arm_reg <= 1'b0;
      end else if (wr_ctrl & avs_byteenable_i[0] & wdata[`MCT_CTL_SET_READ]) begin
        permit_arm_reg <= 1'b1;
      end
      if (wr_ctrl & avs_byteenable_i[1]) begin
        phase_reg     <= wr_phase;
        strobe_reg    <= wdata[`MCT_CTL_STROBE];
        activate_reg  <= wdata[`MCT_CTL_ACTIVATE];
        byte_type_reg <= wdata[`MCT_CTL_BYTE_TYPE];
      end
    end
  end

endmodule

// >>> mct_trunk_if_tb.sv
`include "mct_consts.vh"

module mct_trunk_if_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, pbus_n, p;
  logic [3:0]  pwr_on, end_req, rdy_req, sel, power, t_end, t_rdy, strobe;
  logic [35:0] din;
  logic [8:0]  dout, v, bpath;
  logic        rel, sce, sinh, rd_in, rd_reg, intr, nz, rd_in_d, agg, rdy, bp_req;
  logic [7:0]  icode, pdata;
  logic [1:0]  cc, caddr;
  logic [31:0] exp_q [$];
  int          num_errors, n_compared;
  logic [15:0] ctl_tab [9] = '{16'h0102, 16'h0302, 16'h0202, 16'h0204, 16'h0208,
                               16'h020C, 16'h0104, 16'h0010, 16'h0020};
  logic [8:0]  set_tab [9] = '{9'h008, 9'h008, 9'h000, 9'h020, 9'h040,
                               9'h020, 9'h000, 9'h006, 9'h080};

  mct_trunk_if mct_trunk_if_inst (
    .core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o(),
    .trunk_device_power_i(power), .trunk_service_select_i(sel), .trunk_end_i(t_end),
    .trunk_ready_i(t_rdy), .trunk_din_i(din), .channel_output_reg_o(dout),
    .trunk_strobe_o(strobe), .trunk_activate_o(), .byte_type_qualifier_o(),
    .input_permit_release_i(rel), .selector_channel_end_i(sce), .selector_inhibit_i(sinh),
    .processor_bus_n_i(pbus_n), .instruction_code_i(icode), .condition_code_i(cc),
    .interrupt_cond_i(intr), .n_count_zero_i(nz), .channel_char_address_i(caddr),
    .read_input_command_i(rd_in), .read_register_command_i(rd_reg),
    .internal_bus_inverted_o(), .byte_path_bits_o(bpath), .processor_data_o(pdata),
    .aggregate_end_o(), .aggregate_end_n_o(), .combined_end_o(), .channel_end_request_o(),
    .end_lamp_o(), .status_level_o()
  );

  mct_ce_model mct_ce_model_inst (
    .core_clk_i, .pwr_on_i(pwr_on), .end_req_i(end_req), .rdy_req_i(rdy_req),
    .strobe_i(strobe), .dout_i(dout), .power_o(power), .end_o(t_end), .ready_o(t_rdy),
    .din_o(din)
  );

  // ----------------------------------------------------------------------
  // Clock, checking and closing
  // ----------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic finish_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
    n_compared++;
    if (got !== e) begin
      $display("Error at %0t: got %h expected %h", $time, got, e);
      num_errors++;
    end
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge core_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) check(avs_readdata_o);
    if (rd_in_d === 1'b1) check({24'h0, pdata});
    if (bp_req === 1'b1) check({23'h0, bpath});
    rd_in_d <= rd_in | rd_reg;
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk_i);
    num_errors++;
    finish_test();
  end

  // Avalon cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_write_i      <= w;
    avs_read_i       <= !w;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      num_errors++;
      finish_test();
    end
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // Read input or read register command with a given character address
  task automatic pdata_chk(input logic rreg, input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    caddr  <= a;
    rd_in  <= !rreg;
    rd_reg <= rreg;
    @(posedge core_clk_i);
    rd_in  <= 1'b0;
    rd_reg <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // Byte path sampled for one cycle with a given selector inhibit
  task automatic bpath_chk(input logic inh, input logic [8:0] e);
    exp_q.push_back({23'h0, e});
    sinh   <= inh;
    bp_req <= 1'b1;
    @(posedge core_clk_i);
    bp_req <= 1'b0;
    sinh   <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    {avs_read_i, avs_write_i, avs_address_i, avs_byteenable_i, avs_writedata_i} = '0;
    {pwr_on, end_req, rdy_req, sel, icode, cc, caddr, pbus_n} = '0;
    {rel, sce, sinh, rd_in, rd_reg, intr, nz, bp_req} = '0;
    void'($urandom(32'h4058B493));
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rd(`MCT_OFF_STAT, 32'h0);
    rd(`MCT_OFF_DOUT, 32'h0);
    rd(4'h2, 32'h0);
    // Random end, ready, power and select mixes
    for (int i = 0; i < 16; i++) begin
      rdy_req <= 4'h0;
      wr(`MCT_OFF_CTRL, 32'h40, 4'hF);
      {pwr_on, end_req, rdy_req, sel} <= 16'($urandom);
      {sce, sinh} <= 2'($urandom);
      repeat (2) @(posedge core_clk_i);
      agg = |(end_req & pwr_on & sel);
      rdy = |(rdy_req & pwr_on & sel);
      rd(`MCT_OFF_STAT, {24'h0, agg, agg | sce, 1'b0, rdy, 4'h0});
    end
    {end_req, rdy_req, sce, sinh} <= '0;
    pwr_on <= 4'hF;
    // Direct sets of the output byte per phase
    for (int i = 0; i < 9; i++) begin
      wr(`MCT_OFF_CTRL, 32'hC0, 4'hF);
      wr(`MCT_OFF_CTRL, {16'h0, ctl_tab[i]}, 4'hF);
      rd(`MCT_OFF_DOUT, {23'h0, set_tab[i]});
    end
    p = $urandom;
    pbus_n <= p;
    v = ~p[8:0];
    wr(`MCT_OFF_CTRL, 32'hC0, 4'hF);
    wr(`MCT_OFF_DOUT, 32'h0, 4'h3);
    rd(`MCT_OFF_DOUT, {23'h0, v});
    wr(`MCT_OFF_CTRL, 32'h0102, 4'hF);
    v = v | 9'h008;
    rd(`MCT_OFF_DOUT, {23'h0, v});
    // Strobe trunk 2, then receive from it and from trunk 1
    sel <= 4'h4;
    wr(`MCT_OFF_CTRL, 32'h1C00, 4'hF);
    wr(`MCT_OFF_CTRL, 32'h0, 4'hF);
    wr(`MCT_OFF_CTRL, 32'h1, 4'hF);
    rd(`MCT_OFF_STAT, 32'h22);
    bpath_chk(1'b0, 9'h000);
    rd(`MCT_OFF_DIN, {23'h0, v});
    sel <= 4'h2;
    @(posedge core_clk_i);
    rd(`MCT_OFF_DIN, 32'h51);
    pdata_chk(1'b0, 2'h1, 8'h00);
    pdata_chk(1'b0, 2'h0, 8'h51);
    pdata_chk(1'b1, 2'h0, v[7:0]);
    rel <= 1'b1;
    @(posedge core_clk_i);
    rel <= 1'b0;
    @(posedge core_clk_i);
    rd(`MCT_OFF_STAT, 32'h0);
    rd(`MCT_OFF_DIN, 32'h0);
    // Halt I/O waits in 4B2 for ready, then sends; test device with interrupt
    icode <= `MCT_OP_HALT_IO;
    repeat (3) @(posedge core_clk_i);
    icode <= 8'h00;
    rd(`MCT_OFF_STAT, 32'h01);
    wr(`MCT_OFF_CTRL, 32'h1, 4'hF);
    bpath_chk(1'b0, 9'h051);
    bpath_chk(1'b1, 9'h000);
    rdy_req <= 4'h2;
    rd(`MCT_OFF_STAT, 32'h21);
    rd(`MCT_OFF_STAT, 32'h33);
    icode <= `MCT_OP_TEST_DEV;
    intr  <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    {icode, intr} <= '0;
    rd(`MCT_OFF_STAT, 32'h36);
    rdy_req <= 4'h0;
    wr(`MCT_OFF_CTRL, 32'h40, 4'hF);
    rel <= 1'b1;
    @(posedge core_clk_i);
    rel <= 1'b0;
    @(posedge core_clk_i);
    rd(`MCT_OFF_STAT, 32'h0);
    finish_test();
  end
endmodule
